// file: hdl/ofm_pkg.sv
// Purpose: shared constants for frame memory map and power sequencing
// Assumes: 40 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived
package ofm_pkg;
  // =====================================================================
  // geometry
  localparam int unsigned NUM_COLS   = 132;
  localparam int unsigned NUM_ROWS   = 64;
  localparam int unsigned NUM_PAGES  = 8;
  localparam int unsigned COL_W      = 8;
  localparam int unsigned ROW_W      = 6;
  localparam int unsigned PAGE_W     = 3;
  localparam logic [COL_W-1:0] COL_LAST = 8'h83;
  localparam logic [ROW_W-1:0] ROW_LAST = 6'h3f;
  // =====================================================================
  // commands
  localparam logic [7:0] CMD_DISP_ON  = 8'haf;
  localparam logic [7:0] CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] CMD_SEG_NORM = 8'ha0;
  localparam logic [7:0] CMD_SEG_REV  = 8'ha1;
  localparam logic [7:0] CMD_COM_NORM = 8'hc0;
  localparam logic [7:0] CMD_COM_REV  = 8'hc8;
  localparam logic [7:0] CMD_PAGE_BASE = 8'hb0;
  localparam logic [7:0] CMD_COL_LO   = 8'h00;
  localparam logic [7:0] CMD_COL_HI   = 8'h10;
  // =====================================================================
  // timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned RST_LOW_NS   = 3000;
  localparam int unsigned VCC_WAIT_NS  = 3000;
  localparam int unsigned DISP_ON_MS   = 100;
  localparam int unsigned TOFF_MIN_MS  = 80;
  localparam int unsigned RST_LOW_CYC  =
    (RST_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned VCC_WAIT_CYC =
    (VCC_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DISP_ON_CYC  = DISP_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned TOFF_CYC     = TOFF_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W        = 23;
endpackage

// file: hdl/ofm_link_if.sv
// Purpose: link between host sequencer and display driver
// Assumes: single clock, host drives all strobes
// Notes:   write-only byte bus plus supply enables
`timescale 1ns/1ps
`default_nettype none
interface ofm_link_if;
  logic       hw_init_low_input;
  logic       wr_stb;
  logic       dc_sel;
  logic [7:0] wr_data;
  logic       logic_sup_en;
  logic       io_logic_supply;
  logic       panel_hv_en;
  modport host (output hw_init_low_input, output wr_stb, output dc_sel,
                output wr_data, output logic_sup_en,
                output io_logic_supply, output panel_hv_en);
  modport dev  (input hw_init_low_input, input wr_stb, input dc_sel,
                input wr_data, input logic_sup_en,
                input io_logic_supply, input panel_hv_en);
endinterface
`default_nettype wire

// file: hdl/ofm_dev.sv
// Purpose: display driver frame memory, remap and display-on timing
// Assumes: host keeps power sequence; strobes are on clk_sys_i
// Notes:   panel scan is one pixel per read, addressed by scan_seg_i and scan_com_i
// How it works
// - 132 by 64 one-bit frame memory
// - segment and common reversal chosen independently
// - column remap reverses 0x00..0x83 segment order
// - host holds init low at least 3 us
// - host waits 3 us before high voltage
// - host sends 0xAF after high voltage stable
// - outputs drive 100 ms after display-on
// - host sends 0xAE before high voltage off
// - host waits 80 ms before logic off
// - data/command select high means display data
// - init low input resets driver state
`timescale 1ns/1ps
`default_nettype none
module ofm_dev
  import ofm_pkg::*;
#(
  parameter int unsigned DISP_ON_CYCLES = ofm_pkg::DISP_ON_CYC
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_b_i,
  ofm_link_if.dev                        link,
  input  wire logic [ofm_pkg::COL_W-1:0] scan_seg_i,
  input  wire logic [ofm_pkg::ROW_W-1:0] scan_com_i,
  output logic                           pixel_o,
  output logic                           drive_en_o,
  output logic                           seg_rev_o,
  output logic                           com_rev_o
);
  import ofm_pkg::*;

  typedef enum logic [1:0] {
    OFM_D_OFF  = 2'b00,
    OFM_D_WAIT = 2'b01,
    OFM_D_ON   = 2'b11
  } ofm_dstate_t;

  // =====================================================================
  // pin synchronisers
  logic [2:0] init_s_r, wr_s_r;
  logic       init_low, wr_rise, wr_lvl_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      init_s_r <= 3'h0;
      wr_s_r   <= 3'h0;
      wr_lvl_r <= 1'b0;
    end else begin
      init_s_r <= {init_s_r[1:0], link.hw_init_low_input};
      wr_s_r   <= {wr_s_r[1:0], link.wr_stb};
      if (wr_s_r[1] == wr_s_r[2]) begin
        wr_lvl_r <= wr_s_r[2];
      end
    end
  end
  // init counts low only once both late stages agree
  assign init_low = !init_s_r[1] && !init_s_r[2];
  assign wr_rise  = (wr_s_r[1] == wr_s_r[2]) && wr_s_r[2] && !wr_lvl_r;

  // =====================================================================
  // frame memory: one 8-bit word per page and column
  // 8 pages x 132 columns = 1056 words, so the word index needs 11 bits;
  // a 10-bit index would fold the top of page 7 onto page 0
  logic [7:0] fmem [NUM_PAGES*NUM_COLS];
  logic [PAGE_W-1:0] page_r, page_nxt;
  logic [COL_W-1:0]  col_r, col_nxt;
  logic              seg_rev_r, seg_rev_nxt, com_rev_r, com_rev_nxt;
  logic              on_req, off_req, mem_we;
  // dc and data are stable long before the strobe edge is seen
  always_comb begin
    page_nxt    = page_r;
    col_nxt     = col_r;
    seg_rev_nxt = seg_rev_r;
    com_rev_nxt = com_rev_r;
    on_req      = 1'b0;
    off_req     = 1'b0;
    mem_we      = 1'b0;
    if (wr_rise) begin
      if (link.dc_sel) begin
        mem_we  = 1'b1;
        col_nxt = (col_r == COL_LAST) ? '0 : col_r + 8'h01;
      end else begin
        case (link.wr_data)
          CMD_DISP_ON:  on_req = 1'b1;
          CMD_DISP_OFF: off_req = 1'b1;
          CMD_SEG_NORM: seg_rev_nxt = 1'b0;
          CMD_SEG_REV:  seg_rev_nxt = 1'b1;
          CMD_COM_NORM: com_rev_nxt = 1'b0;
          CMD_COM_REV:  com_rev_nxt = 1'b1;
          default: begin
            if (link.wr_data[7:3] == CMD_PAGE_BASE[7:3]) begin
              page_nxt = link.wr_data[2:0];
            end else if (link.wr_data[7:4] == CMD_COL_LO[7:4]) begin
              col_nxt = {col_r[7:4], link.wr_data[3:0]};
            end else if (link.wr_data[7:4] == CMD_COL_HI[7:4]) begin
              col_nxt = {link.wr_data[3:0], col_r[3:0]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || init_low) begin
      page_r    <= '0;
      col_r     <= '0;
      seg_rev_r <= 1'b0;
      com_rev_r <= 1'b0;
    end else begin
      page_r    <= page_nxt;
      col_r     <= col_nxt;
      seg_rev_r <= seg_rev_nxt;
      com_rev_r <= com_rev_nxt;
    end
  end

  // memory has no reset; contents survive a hardware init
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      fmem[11'(page_r) * 11'(NUM_COLS) + 11'(col_r)] <= link.wr_data;
    end
  end

  // =====================================================================
  // scan readout with remap
  logic [COL_W-1:0] ram_col;
  logic [ROW_W-1:0] ram_row;
  logic [7:0]       rd_word;
  logic             pix_nxt, pix_r;
  always_comb begin
    ram_col = seg_rev_r ? COL_LAST - scan_seg_i : scan_seg_i;
    ram_row = com_rev_r ? ROW_LAST - scan_com_i : scan_com_i;
    rd_word = 8'h00;
    // reversed index past the last column wraps high and reads blank
    if (ram_col <= COL_LAST) begin
      rd_word = fmem[11'(ram_row[5:3]) * 11'(NUM_COLS) + 11'(ram_col)];
    end
    // row bits 5:3 pick the page, bits 2:0 the bit inside the word
    pix_nxt = rd_word[ram_row[2:0]];
  end

  // =====================================================================
  // display on latency
  // off during the wait aborts it, so a quick on/off never drives
  // the panel; the count restarts on the next on command
  ofm_dstate_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      OFM_D_OFF: begin
        if (on_req) begin
          st_nxt  = OFM_D_WAIT;
          cnt_nxt = CNT_W'(DISP_ON_CYCLES - 1);
        end
      end
      OFM_D_WAIT: begin
        if (off_req) begin
          st_nxt = OFM_D_OFF;
        end else if (cnt_r == '0) begin
          st_nxt = OFM_D_ON;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      OFM_D_ON: begin
        if (off_req) begin
          st_nxt = OFM_D_OFF;
        end
      end
      default: st_nxt = OFM_D_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || init_low) begin
      st_r  <= OFM_D_OFF;
      cnt_r <= '0;
      pix_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      pix_r <= pix_nxt;
    end
  end

  assign drive_en_o = (st_r == OFM_D_ON);
  // pixel blanked while outputs are not driven
  assign pixel_o    = pix_r && drive_en_o;
  assign seg_rev_o  = seg_rev_r;
  assign com_rev_o  = com_rev_r;
endmodule
`default_nettype wire

// file: hdl/ofm_host.sv
// Purpose: host side power sequencer and byte writer
// Assumes: user requests power up/down and byte writes
// Notes:   one write per 8 cycles keeps bus strobes slow
`timescale 1ns/1ps
`default_nettype none
module ofm_host
  import ofm_pkg::*;
#(
  parameter int unsigned TOFF_CYCLES = ofm_pkg::TOFF_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  ofm_link_if.host        link,
  input  wire logic       pwr_up_i,
  input  wire logic       pwr_dn_i,
  input  wire logic       hv_stable_i,
  input  wire logic       wr_valid_i,
  input  wire logic       wr_dc_i,
  input  wire logic [7:0] wr_data_i,
  output logic            wr_ready_o,
  output logic            powered_o
);
  import ofm_pkg::*;

  typedef enum logic [3:0] {
    OFM_H_IDLE  = 4'b0000,
    OFM_H_RST   = 4'b0001,
    OFM_H_HVW   = 4'b0011,
    OFM_H_HVON  = 4'b0010,
    OFM_H_ON    = 4'b0110,
    OFM_H_OFF   = 4'b0111,
    OFM_H_TOFF  = 4'b0101
  } ofm_hstate_t;

  // =====================================================================
  // sequencer
  ofm_hstate_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] ph_r, ph_nxt;
  logic       busy, res_low_r, res_low_nxt, hv_r, hv_nxt, sup_r, sup_nxt;
  logic       stb_r, stb_nxt, dc_r, dc_nxt, on_r, on_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic       seq_wr, seq_dc;
  logic [7:0] seq_dat;
  assign busy = (ph_r != 3'h0);
  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r; res_low_nxt = res_low_r;
    hv_nxt = hv_r; sup_nxt = sup_r; on_nxt = on_r;
    seq_wr = 1'b0; seq_dc = 1'b0; seq_dat = 8'h00;
    if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
    case (st_r)
      OFM_H_IDLE: if (pwr_up_i) begin
        sup_nxt = 1'b1; res_low_nxt = 1'b1; st_nxt = OFM_H_RST;
        // both 3 us waits start at the reset fall
        cnt_nxt = CNT_W'(RST_LOW_CYC - 1);
      end
      OFM_H_RST: if (cnt_r == '0) begin
        res_low_nxt = 1'b0; st_nxt = OFM_H_HVW;
      end
      OFM_H_HVW: begin
        // equal 3 us figures, so reset release already covers it
        hv_nxt = 1'b1; st_nxt = OFM_H_HVON;
      end
      OFM_H_HVON: if (hv_stable_i && !busy) begin
        seq_wr = 1'b1; seq_dat = CMD_DISP_ON;
        on_nxt = 1'b1; st_nxt = OFM_H_ON;
      end
      OFM_H_ON: if (pwr_dn_i && !busy) begin
        seq_wr = 1'b1; seq_dat = CMD_DISP_OFF;
        on_nxt = 1'b0; st_nxt = OFM_H_OFF;
      end
      OFM_H_OFF: if (!busy) begin
        hv_nxt = 1'b0; st_nxt = OFM_H_TOFF;
        cnt_nxt = CNT_W'(TOFF_CYCLES - 1);
      end
      OFM_H_TOFF: if (cnt_r == '0) begin
        sup_nxt = 1'b0; st_nxt = OFM_H_IDLE;
      end
      default: st_nxt = OFM_H_IDLE;
    endcase
  end

  // =====================================================================
  // byte writer: strobe high phases 2..5, data set one phase early
  assign wr_ready_o = (st_r == OFM_H_ON) && !busy && !pwr_dn_i;
  always_comb begin
    ph_nxt = busy ? ph_r + 3'h1 : ph_r;
    dc_nxt = dc_r; dat_nxt = dat_r;
    if (seq_wr) begin
      ph_nxt = 3'h1; dc_nxt = seq_dc; dat_nxt = seq_dat;
    end else if (wr_valid_i && wr_ready_o) begin
      ph_nxt = 3'h1; dc_nxt = wr_dc_i; dat_nxt = wr_data_i;
    end
    stb_nxt = (ph_nxt >= 3'h2) && (ph_nxt <= 3'h5);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r <= OFM_H_IDLE; cnt_r <= '0; ph_r <= 3'h0;
      res_low_r <= 1'b0; hv_r <= 1'b0; sup_r <= 1'b0; on_r <= 1'b0;
      stb_r <= 1'b0; dc_r <= 1'b0; dat_r <= 8'h00;
    end else begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; ph_r <= ph_nxt;
      res_low_r <= res_low_nxt; hv_r <= hv_nxt; sup_r <= sup_nxt;
      on_r <= on_nxt; stb_r <= stb_nxt; dc_r <= dc_nxt; dat_r <= dat_nxt;
    end
  end

  assign link.hw_init_low_input = !res_low_r;
  assign link.wr_stb            = stb_r;
  assign link.dc_sel            = dc_r;
  assign link.wr_data           = dat_r;
  assign link.logic_sup_en      = sup_r;
  assign link.io_logic_supply   = sup_r;
  assign link.panel_hv_en       = hv_r;
  assign powered_o              = on_r;
endmodule
`default_nettype wire

// file: test/ofm_props.sv
// Purpose: link assertions for host power sequencing and writes
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the shared link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ofm_props
  import ofm_pkg::*;
#(
  parameter int unsigned TOFF_CYCLES = 50
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       hw_init_low_input,
  input wire logic       wr_stb,
  input wire logic       dc_sel,
  input wire logic [7:0] wr_data,
  input wire logic       logic_sup_en,
  input wire logic       io_logic_supply,
  input wire logic       panel_hv_en
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ===================================================================
  // helper counters
  logic [31:0] lo_r, lo_nxt, off_r, off_nxt;
  logic        ae_r, ae_nxt;
  wire         cmd_w = wr_stb && !dc_sel;
  always_comb begin
    lo_nxt = hw_init_low_input ? 32'h0 : lo_r + 32'h1;
    off_nxt = panel_hv_en ? 32'h0 : off_r + 32'h1;
    ae_nxt = ae_r;
    if (cmd_w && wr_data == CMD_DISP_OFF) ae_nxt = 1'h1;
    if (cmd_w && wr_data == CMD_DISP_ON) ae_nxt = 1'h0;
  end
  always_ff @(posedge clk_sys_i) begin
    lo_r <= rst_b_i ? lo_nxt : 32'h0;
    off_r <= rst_b_i ? off_nxt : 32'h0;
    ae_r <= rst_b_i ? ae_nxt : 1'h0;
  end
  // ===================================================================
  // properties
  property p_init_len;
    $rose(hw_init_low_input) |-> lo_r >= RST_LOW_CYC;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init low pulse too short");
  property p_init_sup;
    $fell(hw_init_low_input) |-> logic_sup_en && io_logic_supply;
  endproperty
  a_init_sup: assert property (p_init_sup)
    else $error("init pulse without logic supplies");
  property p_hv_on;
    $rose(panel_hv_en) |-> hw_init_low_input && logic_sup_en;
  endproperty
  a_hv_on: assert property (p_hv_on)
    else $error("high voltage on before init released");
  property p_on_cmd;
    cmd_w && wr_data == CMD_DISP_ON |-> panel_hv_en;
  endproperty
  a_on_cmd: assert property (p_on_cmd)
    else $error("display on sent without high voltage");
  property p_hv_off;
    $fell(panel_hv_en) |-> ae_r;
  endproperty
  a_hv_off: assert property (p_hv_off)
    else $error("high voltage off before display off");
  property p_sup_off;
    $fell(logic_sup_en) |-> !panel_hv_en && off_r >= TOFF_CYCLES;
  endproperty
  a_sup_off: assert property (p_sup_off)
    else $error("logic supplies off too early");
  property p_stb_len;
    $rose(wr_stb) |=> wr_stb [*3] ##1 !wr_stb;
  endproperty
  a_stb_len: assert property (p_stb_len)
    else $error("write strobe not four cycles");
  property p_dc_hold;
    wr_stb |-> $stable(dc_sel) && $stable(wr_data);
  endproperty
  a_dc_hold: assert property (p_dc_hold)
    else $error("select or data moved under strobe");
  property p_wr_live;
    $rose(wr_stb) |-> hw_init_low_input && logic_sup_en;
  endproperty
  a_wr_live: assert property (p_wr_live)
    else $error("write while in init or unpowered");
  c_on: cover property (cmd_w && wr_data == CMD_DISP_ON);
  c_off: cover property (cmd_w && wr_data == CMD_DISP_OFF);
  c_sup: cover property ($fell(logic_sup_en));
endmodule
`default_nettype wire

// file: test/ofm_bench.sv
// Purpose: both ends joined, frame map and power sequence checked
// Assumes: shortened display-on and power-off counts
// Notes:   writes settle 8 cycles before any look at the outputs
`timescale 1ns/1ps
`default_nettype none
module ofm_bench;
  import ofm_pkg::*;
  localparam int unsigned TOFF = 50;
  logic       clk_sys_i = 1'b0, rst_b_i = 1'b0;
  logic       pwr_up_i = 1'b0, pwr_dn_i = 1'b0, hv_stable_i = 1'b0;
  logic       wr_valid_i = 1'b0, wr_dc_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00, scan_seg_i = 8'h00;
  logic [5:0] scan_com_i = 6'h00;
  logic       wr_ready_o, powered_o, pixel_o;
  logic       drive_en_o, seg_rev_o, com_rev_o;
  int         n_fail = 0, total_checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // supply reports stable one cycle after enable
  always @(posedge clk_sys_i) hv_stable_i <= ofm_link_if_i.panel_hv_en;
  ofm_link_if ofm_link_if_i ();
  ofm_host #(.TOFF_CYCLES(TOFF)) ofm_host_i (.clk_sys_i, .rst_b_i,
    .link(ofm_link_if_i), .pwr_up_i, .pwr_dn_i, .hv_stable_i,
    .wr_valid_i, .wr_dc_i, .wr_data_i, .wr_ready_o, .powered_o);
  ofm_dev #(.DISP_ON_CYCLES(50)) ofm_dev_i (.clk_sys_i, .rst_b_i,
    .link(ofm_link_if_i), .scan_seg_i, .scan_com_i, .pixel_o,
    .drive_en_o, .seg_rev_o, .com_rev_o);
  ofm_props #(.TOFF_CYCLES(TOFF)) ofm_props_i (.clk_sys_i, .rst_b_i,
    .hw_init_low_input(ofm_link_if_i.hw_init_low_input),
    .wr_stb(ofm_link_if_i.wr_stb),
    .dc_sel(ofm_link_if_i.dc_sel),
    .wr_data(ofm_link_if_i.wr_data),
    .logic_sup_en(ofm_link_if_i.logic_sup_en),
    .io_logic_supply(ofm_link_if_i.io_logic_supply),
    .panel_hv_en(ofm_link_if_i.panel_hv_en));
  // ===================================================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int k);
    for (int i = 0; i < k && s !== v; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (s !== v) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, s, v);
      end_of_test();
    end
  endtask
  task automatic wr(input logic dc, input logic [7:0] d);
    wt(wr_ready_o, 1'b1, 400);
    @(posedge clk_sys_i);
    wr_valid_i <= 1'b1;
    wr_dc_i <= dc;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_valid_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic at(input logic [2:0] pg, input logic [7:0] col);
    wr(1'b0, CMD_PAGE_BASE | {5'h00, pg});
    wr(1'b0, CMD_COL_LO | {4'h0, col[3:0]});
    wr(1'b0, CMD_COL_HI | {4'h0, col[7:4]});
  endtask
  task automatic px(input logic [7:0] s, input logic [5:0] c,
                    input logic e);
    @(posedge clk_sys_i);
    scan_seg_i <= s;
    scan_com_i <= c;
    repeat (2) @(posedge clk_sys_i);
    #1 chk(pixel_o, e);
  endtask
  task automatic up();
    @(posedge clk_sys_i);
    pwr_up_i <= 1'b1;
    wt(powered_o, 1'b1, 400);
    @(posedge clk_sys_i);
    pwr_up_i <= 1'b0;
    #1 chk(drive_en_o, 1'b0);
    repeat (40) @(posedge clk_sys_i);
    #1 chk(drive_en_o, 1'b0);
    wt(drive_en_o, 1'b1, 60);
    $display("test power_up done");
  endtask
  // ===================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    up();
    at(3'h0, 8'h00);
    wr(1'b1, 8'h01);
    at(3'h7, COL_LAST);
    wr(1'b1, 8'h80);
    wr(1'b1, 8'h00);
    px(8'h00, 6'h00, 1'b1);
    px(8'h00, 6'h01, 1'b0);
    px(8'h83, 6'h3f, 1'b1);
    px(8'h83, 6'h3e, 1'b0);
    $display("test frame_map done");
    wr(1'b0, CMD_SEG_REV);
    chk(seg_rev_o, 1'b1);
    chk(com_rev_o, 1'b0);
    px(8'h83, 6'h00, 1'b1);
    px(8'h00, 6'h3f, 1'b1);
    wr(1'b0, CMD_COM_REV);
    chk(com_rev_o, 1'b1);
    px(8'h83, 6'h3f, 1'b1);
    px(8'h00, 6'h00, 1'b1);
    wr(1'b0, CMD_SEG_NORM);
    wr(1'b0, CMD_COM_NORM);
    px(8'h00, 6'h3f, 1'b0);
    $display("test remap done");
    // off code sent as data must land in memory only
    at(3'h3, 8'h10);
    wr(1'b1, CMD_DISP_OFF);
    chk(drive_en_o, 1'b1);
    px(8'h10, 6'h19, 1'b1);
    px(8'h10, 6'h18, 1'b0);
    $display("test data_select done");
    wr(1'b0, CMD_SEG_REV);
    @(posedge clk_sys_i);
    pwr_dn_i <= 1'b1;
    wt(powered_o, 1'b0, 400);
    #1 chk(wr_ready_o, 1'b0);
    @(posedge clk_sys_i);
    pwr_dn_i <= 1'b0;
    repeat (TOFF + 20) @(posedge clk_sys_i);
    #1 chk(ofm_link_if_i.logic_sup_en, 1'b0);
    chk(drive_en_o, 1'b0);
    up();
    chk(seg_rev_o, 1'b0);
    px(8'h00, 6'h00, 1'b1);
    $display("test power_cycle done");
    end_of_test();
  end
endmodule
`default_nettype wire
